// ### hw/ssc_top.sv
// Top of the sleep and external interrupt sense control register block.
// Assumes a core that drives the register port and the sleep pulse, and external pins on the lines.
//
// What this block does
// - Sleep instruction sleeps only when armed.
// - Depth bit picks idle or power-down.
// - Line one needs global enable and mask.
// - Sense 00 requests while line low.
// - Sense 10 requests on falling edge.
// - Sense 11 requests on rising edge.
// - Line zero uses same sense encoding.
// - Pins sampled by clock before edge detection.
// - Level mode requests while pin stays low.
`include "ssc_cfg.svh"
module ssc_top (
	input wire logic MCLK_IN, // Clock, 200 MHz.
	input wire logic RESET_N_IN, // Asynchronous reset, active low.
	input wire logic [7:0] ADDR_IN, // Register address.
	input wire logic [7:0] WDATA_IN, // Write data.
	input wire logic WR_IN, // Write strobe.
	input wire logic RD_IN, // Read strobe.
	output logic [7:0] RDATA_OUT, // Read data, cycle after strobe.
	input wire logic GLOBAL_IRQ_EN_IN, // Global interrupt enable flag of the status word.
	input wire logic LINE0_MASK_IN, // Line zero mask bit of the external mask register.
	input wire logic LINE1_MASK_IN, // Line one mask bit of the external mask register.
	input wire logic EXTERNAL_LINE_ZERO_IN, // External interrupt pin zero.
	input wire logic EXTERNAL_LINE_ONE_IN, // External interrupt pin one.
	input wire logic SLEEP_INSTR_IN, // Sleep instruction executed, one-cycle pulse.
	input wire logic OTHER_WAKE_IN, // Other enabled interrupt that wakes from idle.
	output logic LINE0_IRQ_OUT, // Line zero interrupt request to the core.
	output logic LINE1_IRQ_OUT, // Line one interrupt request to the core.
	output logic IDLE_OUT, // Device in idle.
	output logic POWER_DOWN_OUT // Device in power-down.
);
	logic [7:0] ctrl;
	logic [7:0] rdata;
	logic irq0;
	logic irq1;
	ssc_pkg::ssc_state_t state;
	ssc_line_if line0 ();
	ssc_line_if line1 ();

	wire logic wr_ctrl = WR_IN && (ADDR_IN == `SSC_CTRL_ADDR);
	wire logic sel_ctrl = ADDR_IN == `SSC_CTRL_ADDR;
	wire logic sel_stat = ADDR_IN == `SSC_STAT_ADDR;
	// Bits 7 and 6 are reserved; masking the write keeps them reading as zero.
	wire logic [7:0] next_ctrl = wr_ctrl ? (WDATA_IN & `SSC_CTRL_WMASK) : ctrl;
	wire logic [7:0] stat_word = {5'h00, state == ssc_pkg::SSC_PDOWN, state == ssc_pkg::SSC_IDLE, 1'b0};
	wire logic [7:0] next_rdata = !RD_IN ? 8'h00 : sel_ctrl ? ctrl : sel_stat ? stat_word : 8'h00;

	assign line0.sense = {ctrl[`SSC_L0_HI], ctrl[`SSC_L0_LO]};
	assign line0.pin = EXTERNAL_LINE_ZERO_IN;
	assign line1.sense = {ctrl[`SSC_L1_HI], ctrl[`SSC_L1_LO]};
	assign line1.pin = EXTERNAL_LINE_ONE_IN;

	// A request that is masked is dropped here, not held; level mode repeats it while the pin stays low.
	wire logic next_irq0 = GLOBAL_IRQ_EN_IN & LINE0_MASK_IN & line0.request;
	wire logic next_irq1 = GLOBAL_IRQ_EN_IN & LINE1_MASK_IN & line1.request;
	wire logic wake_pd = (GLOBAL_IRQ_EN_IN & LINE0_MASK_IN & line0.wake) |
		(GLOBAL_IRQ_EN_IN & LINE1_MASK_IN & line1.wake);
	wire logic wake_any = next_irq0 | next_irq1 | OTHER_WAKE_IN;

	ssc_line_det u_det0 (
		.clk_in(MCLK_IN),
		.rst_n_in(RESET_N_IN),
		.line(line0)
	);
	ssc_line_det u_det1 (
		.clk_in(MCLK_IN),
		.rst_n_in(RESET_N_IN),
		.line(line1)
	);
	ssc_sleep_fsm u_fsm (
		.clk_in(MCLK_IN),
		.rst_n_in(RESET_N_IN),
		.sleep_instr_in(SLEEP_INSTR_IN),
		.arm_in(ctrl[`SSC_BIT_SLEEP_ARM]),
		.depth_in(ctrl[`SSC_BIT_SLEEP_DEPTH]),
		.wake_any_in(wake_any),
		.wake_pd_in(wake_pd),
		.state_out(state)
	);

	always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			ctrl <= `SSC_CTRL_RESET;
			rdata <= 8'h00;
			irq0 <= 1'b0;
			irq1 <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			rdata <= next_rdata;
			irq0 <= next_irq0;
			irq1 <= next_irq1;
		end
	end

	assign RDATA_OUT = rdata;
	assign LINE0_IRQ_OUT = irq0;
	assign LINE1_IRQ_OUT = irq1;
	assign IDLE_OUT = state == ssc_pkg::SSC_IDLE;
	assign POWER_DOWN_OUT = state == ssc_pkg::SSC_PDOWN;
endmodule // ssc_top

// ### hw/ssc_cfg.svh
// Offsets, field positions, reset values and timing counts for the sleep and sense control block.
// Assumes inclusion by bare name from any design file that needs them.
`ifndef SSC_CFG_SVH
`define SSC_CFG_SVH
`define SSC_CTRL_ADDR 8'h00
`define SSC_STAT_ADDR 8'h01
`define SSC_CTRL_RESET 8'h00
`define SSC_CTRL_WMASK 8'h3f
`define SSC_BIT_SLEEP_ARM 5
`define SSC_BIT_SLEEP_DEPTH 4
`define SSC_L1_HI 3
`define SSC_L1_LO 2
`define SSC_L0_HI 1
`define SSC_L0_LO 0
`define SSC_SENSE_LOW 2'h0
`define SSC_SENSE_RSVD 2'h1
`define SSC_SENSE_FALL 2'h2
`define SSC_SENSE_RISE 2'h3
`define SSC_CLK_PERIOD_NS 5
`define SSC_SYNC_STAGES 2
`endif

// ### hw/ssc_pkg.sv
// Types shared by the sleep and sense control block.
// Assumes nothing of its surroundings.
package ssc_pkg;
	typedef enum logic [2:0] {
		SSC_RUN = 3'h1,
		SSC_IDLE = 3'h2,
		SSC_PDOWN = 3'h4
	} ssc_state_t;
	typedef logic [1:0] ssc_sense_t;
endpackage

// ### hw/ssc_line_if.sv
// Interface carrying one external line's settings and request between modules.
// Assumes a single clock domain.
interface ssc_line_if;
	logic [1:0] sense;
	logic pin;
	logic request;
	logic wake;
	modport ctl (output sense, output pin, input request, input wake);
	modport det (input sense, input pin, output request, output wake);
endinterface

// ### hw/ssc_line_det.sv
// Sense logic for one external interrupt line: synchroniser, edge and level detect.
// Assumes the pin is asynchronous to the clock and sampled here.
`include "ssc_cfg.svh"
module ssc_line_det (
	input wire logic clk_in, // Clock.
	input wire logic rst_n_in, // Asynchronous reset, active low.
	ssc_line_if.det line // Settings in, request out.
);
	logic sync_a;
	logic sync_b;
	logic prev;
	wire logic fell = prev & ~sync_b;
	wire logic rose = ~prev & sync_b;
	wire logic is_low = ~sync_b;
	wire logic next_request = (line.sense == `SSC_SENSE_LOW) ? is_low :
		(line.sense == `SSC_SENSE_FALL) ? fell :
		(line.sense == `SSC_SENSE_RISE) ? rose : 1'b0;
	// All three flops start high so a released line does not look like a rising edge after reset.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sync_a <= 1'b1;
			sync_b <= 1'b1;
			prev <= 1'b1;
		end else begin
			sync_a <= line.pin;
			sync_b <= sync_a;
			prev <= sync_b;
		end
	end
	assign line.request = next_request;
	// Level wake works without a clock edge pattern, which is why only the low level wakes power-down.
	assign line.wake = (line.sense == `SSC_SENSE_LOW) & is_low;
endmodule // ssc_line_det

// ### hw/ssc_sleep_fsm.sv
// Sleep state machine: run, idle and power-down.
// Assumes the core pulses the sleep request for one cycle per sleep instruction.
module ssc_sleep_fsm (
	input wire logic clk_in, // Clock.
	input wire logic rst_n_in, // Asynchronous reset, active low.
	input wire logic sleep_instr_in, // Sleep instruction executed.
	input wire logic arm_in, // Sleep armed.
	input wire logic depth_in, // 0 idle, 1 power-down.
	input wire logic wake_any_in, // Any source allowed to wake from idle.
	input wire logic wake_pd_in, // Sources allowed to wake from power-down.
	output ssc_pkg::ssc_state_t state_out // Current state.
);
	ssc_pkg::ssc_state_t state;
	ssc_pkg::ssc_state_t next_state;
	always_comb begin
		next_state = state;
		case (state)
			ssc_pkg::SSC_RUN: begin
				if (sleep_instr_in && arm_in) begin
					next_state = depth_in ? ssc_pkg::SSC_PDOWN : ssc_pkg::SSC_IDLE;
				end
			end
			ssc_pkg::SSC_IDLE: begin
				if (wake_any_in) begin
					next_state = ssc_pkg::SSC_RUN;
				end
			end
			ssc_pkg::SSC_PDOWN: begin
				if (wake_pd_in) begin
					next_state = ssc_pkg::SSC_RUN;
				end
			end
			default: next_state = ssc_pkg::SSC_RUN;
		endcase
	end
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state <= ssc_pkg::SSC_RUN;
		end else begin
			state <= next_state;
		end
	end
	assign state_out = state;
endmodule // ssc_sleep_fsm

// ### sim/ssc_pin_src.sv
// Partner model: the two sources that drive the external interrupt pins.
// Assumes the bench sets the wanted levels; pins change only on the clock edge.
module ssc_pin_src (
	input wire logic clk_in, // Clock.
	input wire logic [1:0] want_in, // Wanted levels.
	output logic [1:0] pin_out // Pins, bit 0 is line zero.
);
	timeunit 1ns;
	timeprecision 1ps;
	initial pin_out = 2'h3;
	// Whole clock periods only, so every pulse lasts at least one period and a low level is held.
	always @(posedge clk_in) begin
		pin_out <= want_in;
	end
endmodule // ssc_pin_src

// ### sim/ssc_top_assertions.sv
// Checker for the sleep and sense control block.
// Assumes it is bound to the top and sees only its ports.
module ssc_top_assertions (
	input wire logic MCLK_IN, // In.
	input wire logic RESET_N_IN, // In.
	input wire logic [7:0] ADDR_IN, // In.
	input wire logic [7:0] WDATA_IN, // In.
	input wire logic WR_IN, // In.
	input wire logic RD_IN, // In.
	input wire logic [7:0] RDATA_OUT, // In.
	input wire logic GLOBAL_IRQ_EN_IN, // In.
	input wire logic LINE1_MASK_IN, // In.
	input wire logic EXTERNAL_LINE_ONE_IN, // In.
	input wire logic SLEEP_INSTR_IN, // In.
	input wire logic LINE1_IRQ_OUT, // In.
	input wire logic IDLE_OUT, // In.
	input wire logic POWER_DOWN_OUT // In.
);
	logic [7:0] ctl;
	wire logic g1 = GLOBAL_IRQ_EN_IN & LINE1_MASK_IN;
	wire logic run = !IDLE_OUT && !POWER_DOWN_OUT;
	always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			ctl <= 8'h00;
		end else if (WR_IN && ADDR_IN == 8'h00) begin
			ctl <= WDATA_IN & 8'h3f;
		end
	end
	default clocking @(posedge MCLK_IN);
	endclocking
	default disable iff (!RESET_N_IN);
	sequence s_fall;
		$fell(EXTERNAL_LINE_ONE_IN) && ctl[3:2] == 2'h2 && g1 ##1 g1 [*2];
	endsequence
	sequence s_rise;
		$rose(EXTERNAL_LINE_ONE_IN) && ctl[3:2] == 2'h3 && g1 ##1 g1 [*2];
	endsequence
	property p_rd;
		RD_IN && ADDR_IN == 8'h00 |=> RDATA_OUT == $past(ctl);
	endproperty
	a_rd: assert property (p_rd) else $error("control read back wrong");
	property p_unarmed;
		SLEEP_INSTR_IN && !ctl[5] && run |=> run;
	endproperty
	a_unarmed: assert property (p_unarmed) else $error("slept while unarmed");
	property p_depth;
		SLEEP_INSTR_IN && ctl[5] && run |=> IDLE_OUT == !$past(ctl[4]) && POWER_DOWN_OUT == $past(ctl[4]);
	endproperty
	a_depth: assert property (p_depth) else $error("wrong sleep state");
	property p_fall;
		s_fall |-> ##[1:2] LINE1_IRQ_OUT;
	endproperty
	a_fall: assert property (p_fall) else $error("falling edge missed");
	property p_rise;
		s_rise |-> ##[1:2] LINE1_IRQ_OUT;
	endproperty
	a_rise: assert property (p_rise) else $error("rising edge missed");
	property p_low;
		(!EXTERNAL_LINE_ONE_IN && ctl[3:2] == 2'h0 && g1) [*5] |-> LINE1_IRQ_OUT;
	endproperty
	a_low: assert property (p_low) else $error("low level not requested");
	property p_rsvd;
		(ctl[3:2] == 2'h1) [*4] |-> !LINE1_IRQ_OUT;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved sense requested");
	property p_gate;
		!g1 |=> !LINE1_IRQ_OUT;
	endproperty
	a_gate: assert property (p_gate) else $error("request while gated off");
endmodule // ssc_top_assertions
bind ssc_top ssc_top_assertions chk_u (
	.MCLK_IN(MCLK_IN),
	.RESET_N_IN(RESET_N_IN),
	.ADDR_IN(ADDR_IN),
	.WDATA_IN(WDATA_IN),
	.WR_IN(WR_IN),
	.RD_IN(RD_IN),
	.RDATA_OUT(RDATA_OUT),
	.GLOBAL_IRQ_EN_IN(GLOBAL_IRQ_EN_IN),
	.LINE1_MASK_IN(LINE1_MASK_IN),
	.EXTERNAL_LINE_ONE_IN(EXTERNAL_LINE_ONE_IN),
	.SLEEP_INSTR_IN(SLEEP_INSTR_IN),
	.LINE1_IRQ_OUT(LINE1_IRQ_OUT),
	.IDLE_OUT(IDLE_OUT),
	.POWER_DOWN_OUT(POWER_DOWN_OUT)
);

// ### sim/test_sleep_and_ext_irq_sense_ctrl.sv
// Self-checking bench for the sleep and sense control block.
// Assumes the partner model drives both pins.
module test_sleep_and_ext_irq_sense_ctrl;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst_n = 0, wr = 0, rd = 0, sl = 0, ow = 0, ge = 1, idle, pd;
	logic [7:0] addr = 8'h00, wd = 8'h00, rdata;
	logic [1:0] want = 2'h3, pin, irq, mask = 2'h3;
	int n_mismatch = 0, checks_done = 0;
	always #2.5 clk = ~clk;
	ssc_pin_src src_u (.clk_in(clk), .want_in(want), .pin_out(pin));
	ssc_top dut_u (.MCLK_IN(clk), .RESET_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wd), .WR_IN(wr), .RD_IN(rd),
		.RDATA_OUT(rdata), .GLOBAL_IRQ_EN_IN(ge), .LINE0_MASK_IN(mask[0]), .LINE1_MASK_IN(mask[1]),
		.EXTERNAL_LINE_ZERO_IN(pin[0]), .EXTERNAL_LINE_ONE_IN(pin[1]), .SLEEP_INSTR_IN(sl), .OTHER_WAKE_IN(ow),
		.LINE0_IRQ_OUT(irq[0]), .LINE1_IRQ_OUT(irq[1]), .IDLE_OUT(idle), .POWER_DOWN_OUT(pd));
	task automatic finish_test();
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= w;
		rd <= !w;
		addr <= a;
		wd <= d;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
		#1;
	endtask
	task automatic sleep_chk(input logic [7:0] c, input logic [7:0] exp);
		bus(1'b1, 8'h00, c);
		@(posedge clk);
		sl <= 1'b1;
		@(posedge clk);
		sl <= 1'b0;
		@(negedge clk);
		chk({6'h00, idle, pd}, exp);
	endtask
	// A selector rather than a reference, so the watched output stays a plain port connection.
	task automatic wait_low(input logic sel);
		for (int i = 0; i < 20 && (sel ? pd : idle) !== 1'b0; i++) @(negedge clk);
		chk({7'h00, (sel ? pd : idle)}, 8'h00);
		if ((sel ? pd : idle) !== 1'b0) finish_test();
	endtask
	task automatic t_regs();
		bus(1'b0, 8'h00, 8'h00);
		chk(rdata, 8'h00);
		bus(1'b1, 8'h00, 8'hff);
		bus(1'b1, 8'h02, 8'h00);
		bus(1'b0, 8'h00, 8'h00);
		chk(rdata, 8'h3f);
		bus(1'b0, 8'h02, 8'h00);
		chk(rdata, 8'h00);
	endtask
	task automatic t_sleep();
		sleep_chk(8'h10, 8'h00);
		sleep_chk(8'h20, 8'h02);
		bus(1'b0, 8'h01, 8'h00);
		chk(rdata, 8'h02);
		@(posedge clk);
		ow <= 1'b1;
		wait_low(1'b0);
		@(posedge clk);
		ow <= 1'b0;
		sleep_chk(8'h30, 8'h01);
		bus(1'b0, 8'h01, 8'h00);
		chk(rdata, 8'h04);
		@(posedge clk);
		want[1] <= 1'b0;
		wait_low(1'b1);
		@(posedge clk);
		want <= 2'h3;
	endtask
	task automatic t_sense();
		int ln, n;
		logic p;
		// Line, sense code and gating all vary; only ungated non-reserved codes give one request.
		for (int k = 0; k < 16; k++) begin
			ln = k % 2;
			bus(1'b1, 8'h00, 8'(((k / 2) % 4) << (2 * ln)));
			n = 0;
			p = 1'b0;
			@(posedge clk);
			ge <= k < 12;
			mask[ln] <= k < 8 || k >= 12;
			for (int i = 0; i < 14; i++) begin
				@(posedge clk);
				want[ln] <= i >= 6;
				#1;
				if (irq[ln] === 1'b1 && p !== 1'b1) n++;
				p = irq[ln];
			end
			chk(8'(n), ((k / 2) % 4 != 1 && k < 8) ? 8'h01 : 8'h00);
		end
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_sleep();
		t_sense();
		finish_test();
	end
endmodule // test_sleep_and_ext_irq_sense_ctrl
